// [canmode_pkg.sv]
// Purpose: shared constants and types for the transceiver mode and wake block
// Assumes: 25 MHz system clock, APB register access
// Notes: times are kept in their own units and converted to cycles here
// Operation
// [R01] active or listen-only keeps both bus lines at mid-level bias
// [R02] offline goes to offline bias on activity, back after silence timeout
// [R03] normal mode follows mode field; standby and sleep force offline or bias
// [R04] active only with device mode 111 and field 01 or 10, 01 needs supply
// [R05] field 01 supply undervoltage drops active to offline or offline bias
// [R06] field 10 ignores supply undervoltage until sleep is forced
// [R07] transmit input low at active request gives listen-only until it returns high
// [R08] readable status bit shows transceiver in active mode
// [R09] normal mode with field 11 gives listen-only, transmitter off
// [R10] offline biases bus to ground; wake watch only when bus wake enabled
// [R11] leaving active or listen-only goes offline only if bus already silent
// [R12] off or overtemp into standby places transceiver in offline
// [R13] offline to offline bias on wake pattern, or normal field 01 low supply
// [R14] off, overtemp or battery undervoltage turn transceiver off, bus floating
// [R15] standard wake watch when selective wake disabled or config invalid
// [R16] wake pattern is dominant, recessive, dominant phases of minimum length
// [R17] pattern not complete within wake timeout resets the detector
// [R18] receive output high until wake, then event flag set and output low
// [R19] bus wake in sleep raises regulator inhibit and enters standby
// [R20] status bit 7 reads 1 in active mode, else 0
// [R21] every bus edge restarts the silence timer
package canmode_pkg;
    localparam int CLK_HZ = 25000000;
    // times in microseconds, wake phases in nanoseconds
    localparam int SILENCE_US = 1000;
    localparam int WAKE_TO_US = 1000;
    localparam int WAKE_DOM_NS = 5000;
    localparam int WAKE_REC_NS = 5000;
    localparam int SILENCE_CYC = SILENCE_US * (CLK_HZ / 1000000);
    localparam int WAKE_TO_CYC = WAKE_TO_US * (CLK_HZ / 1000000);
    // minimum phases round up
    localparam int WAKE_DOM_CYC = (WAKE_DOM_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int WAKE_REC_CYC = (WAKE_REC_NS * (CLK_HZ / 1000000) + 999) / 1000;

    // register byte addresses
    localparam logic [11:0] ADDR_MODE = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h080;
    localparam logic [11:0] ADDR_STAT = 12'h088;
    localparam logic [11:0] ADDR_EVT = 12'h090;
    // field positions
    localparam int CTRL_FIELD_LSB = 0;
    localparam int CTRL_SEL_EN_BIT = 4;
    localparam int CTRL_CFG_OK_BIT = 5;
    localparam int CTRL_WAKE_EN_BIT = 6;
    localparam int STAT_ACTIVE_BIT = 7;
    localparam int STAT_SILENT_BIT = 3;
    localparam int STAT_MODE_LSB = 0;
    localparam int EVT_WAKE_BIT = 0;
    // device mode and field codes, reset values
    localparam logic [2:0] DEV_SLEEP = 3'h1;
    localparam logic [2:0] DEV_STANDBY = 3'h4;
    localparam logic [2:0] DEV_NORMAL = 3'h7;
    localparam logic [2:0] MODE_RST = 3'h4;
    localparam logic [1:0] FIELD_OFFLINE = 2'h0;
    localparam logic [1:0] FIELD_ACT_UV = 2'h1;
    localparam logic [1:0] FIELD_ACT = 2'h2;
    localparam logic [1:0] FIELD_LISTEN = 2'h3;
    localparam logic [1:0] FIELD_RST = 2'h0;
    localparam logic WAKE_EN_RST = 1'b1;

    typedef enum logic [2:0] {
        XM_OFF, XM_OFFLINE, XM_BIAS, XM_LISTEN, XM_ACTIVE
    } xcvr_mode_t;

    typedef enum logic [1:0] {
        WK_IDLE, WK_DOM1, WK_REC, WK_DOM2
    } wake_state_t;

    // device side conditions, grouped
    typedef struct packed {
        logic offline_forced;   // off or overtemp
        logic bat_uv;
        logic vcc_uv;
        logic uv_sleep;         // supply undervoltage forced sleep
    } supply_t;
endpackage

// [can_transceiver_mode_and_wake.sv]
// Purpose: transceiver mode control plus standard bus wake-up detector
// Assumes: bus receiver level arrives asynchronously; supply flags asynchronous too
// Notes: device mode is held in a register here; the device mode machine lives elsewhere
module can_transceiver_mode_and_wake
    import canmode_pkg::*;
#(
    parameter int SILENCE_CYCLES = SILENCE_CYC,
    parameter int WAKE_TO_CYCLES = WAKE_TO_CYC,
    parameter int DOM_CYCLES = WAKE_DOM_CYC,
    parameter int REC_CYCLES = WAKE_REC_CYC
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // device conditions
    input wire logic OFF_OR_OVERTEMP_I,
    input wire logic BAT_UV_I,
    input wire logic VCC_UV_I,
    input wire logic UV_SLEEP_I,
    // protocol controller and bus
    input wire logic TXD_I,
    input wire logic BUS_DOMINANT_I,
    output logic RXD_O,
    output logic TX_ENABLE_O,
    output logic BIAS_MID_O,
    output logic BIAS_GND_O,
    output logic XCVR_ON_O,
    output logic REGULATOR_INHIBIT_OUT_O
);
    localparam int SW = $clog2(SILENCE_CYCLES + 1);
    localparam int TW = $clog2(WAKE_TO_CYCLES + 1);
    localparam int PW = $clog2((DOM_CYCLES > REC_CYCLES ? DOM_CYCLES : REC_CYCLES) + 1);

    // three flop synchronisers for outside signals
    logic [2:0] bus_s_q, txd_s_q, uv_s_q, bat_s_q, vuv_s_q, usl_s_q;
    logic bus_q, txd_q, off_q, bat_q, vuv_q, usl_q;
    supply_t sup;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bus_s_q <= 3'h0;
            txd_s_q <= 3'h7;
            uv_s_q <= 3'h7;
            bat_s_q <= 3'h0;
            vuv_s_q <= 3'h0;
            usl_s_q <= 3'h0;
        end else begin
            bus_s_q <= {bus_s_q[1:0], BUS_DOMINANT_I};
            txd_s_q <= {txd_s_q[1:0], TXD_I};
            uv_s_q <= {uv_s_q[1:0], OFF_OR_OVERTEMP_I};
            bat_s_q <= {bat_s_q[1:0], BAT_UV_I};
            vuv_s_q <= {vuv_s_q[1:0], VCC_UV_I};
            usl_s_q <= {usl_s_q[1:0], UV_SLEEP_I};
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bus_q <= 1'b0;
            txd_q <= 1'b1;
            off_q <= 1'b1;
            bat_q <= 1'b0;
            vuv_q <= 1'b0;
            usl_q <= 1'b0;
        end else begin
            if (bus_s_q[1] == bus_s_q[2]) bus_q <= bus_s_q[2];
            if (txd_s_q[1] == txd_s_q[2]) txd_q <= txd_s_q[2];
            if (uv_s_q[1] == uv_s_q[2]) off_q <= uv_s_q[2];
            if (bat_s_q[1] == bat_s_q[2]) bat_q <= bat_s_q[2];
            if (vuv_s_q[1] == vuv_s_q[2]) vuv_q <= vuv_s_q[2];
            if (usl_s_q[1] == usl_s_q[2]) usl_q <= usl_s_q[2];
        end
    end

    assign sup = '{offline_forced: off_q, bat_uv: bat_q, vcc_uv: vuv_q, uv_sleep: usl_q};

    // registers
    logic [2:0] dev_mode_q;
    logic [1:0] field_q;
    logic sel_en_q, cfg_ok_q, wake_en_q, wake_evt_q;
    logic [31:0] rdata_q;
    xcvr_mode_t mode_q, mode_d;
    logic silent_q, wake_hit;
    logic [SW-1:0] sil_cnt_q;
    logic bus_prev_q;
    logic edge_seen;
    logic wr_en, rd_en;

    assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    assign PREADY_O = 1'b1;

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = (a == ADDR_MODE) || (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_EVT);
    endfunction

    assign PSLVERR_O = PSEL_I & PENABLE_I & ~known_addr(PADDR_I);

    // uv-forced sleep overrides software mode
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            dev_mode_q <= MODE_RST;
        end else if (sup.uv_sleep && dev_mode_q == DEV_NORMAL) begin
            dev_mode_q <= DEV_SLEEP;
        end else if (wake_hit && dev_mode_q == DEV_SLEEP) begin
            dev_mode_q <= DEV_STANDBY; // R19
        end else if (wr_en && PADDR_I == ADDR_MODE && PSTRB_I[0]) begin
            dev_mode_q <= PWDATA_I[2:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            field_q <= FIELD_RST;
            sel_en_q <= 1'b0;
            cfg_ok_q <= 1'b0;
            wake_en_q <= WAKE_EN_RST;
        end else if (wr_en && PADDR_I == ADDR_CTRL && PSTRB_I[0]) begin
            field_q <= PWDATA_I[CTRL_FIELD_LSB +: 2];
            sel_en_q <= PWDATA_I[CTRL_SEL_EN_BIT];
            cfg_ok_q <= PWDATA_I[CTRL_CFG_OK_BIT];
            wake_en_q <= PWDATA_I[CTRL_WAKE_EN_BIT];
        end
    end

    // event flag: write 1 clears, a new wake wins over the clear
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            wake_evt_q <= 1'b0;
        end else if (wake_hit) begin
            wake_evt_q <= 1'b1; // R18
        end else if (wr_en && PADDR_I == ADDR_EVT && PSTRB_I[0] && PWDATA_I[EVT_WAKE_BIT]) begin
            wake_evt_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rdata_q <= 32'h0;
        end else if (rd_en) begin
            rdata_q <= 32'h0;
            case (PADDR_I)
                ADDR_MODE: rdata_q[2:0] <= dev_mode_q;
                ADDR_CTRL: rdata_q[7:0] <= {1'b0, wake_en_q, cfg_ok_q, sel_en_q, 2'b00, field_q};
                ADDR_STAT: begin
                    rdata_q[STAT_ACTIVE_BIT] <= (mode_q == XM_ACTIVE); // R08 R20
                    rdata_q[STAT_SILENT_BIT] <= silent_q;
                    rdata_q[STAT_MODE_LSB +: 3] <= mode_q;
                end
                ADDR_EVT: rdata_q[EVT_WAKE_BIT] <= wake_evt_q;
                default: rdata_q <= 32'h0;
            endcase
        end
    end
    assign PRDATA_O = rdata_q;

    // bus silence timer
    assign edge_seen = bus_q != bus_prev_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bus_prev_q <= 1'b0;
            sil_cnt_q <= '0;
            silent_q <= 1'b1;
        end else begin
            bus_prev_q <= bus_q;
            if (edge_seen) begin
                sil_cnt_q <= '0; // R21
                silent_q <= 1'b0;
            end else if (sil_cnt_q == SW'(SILENCE_CYCLES)) begin
                silent_q <= 1'b1;
            end else begin
                sil_cnt_q <= sil_cnt_q + 1'b1;
            end
        end
    end

    // wake-up pattern detector
    wake_state_t wk_q;
    logic [PW-1:0] ph_cnt_q;
    logic [TW-1:0] to_cnt_q;
    logic watch;
    // offline bias differs from offline only in its bias level, so the watch stays on there;
    // otherwise the first dominant edge would move to bias and kill the pattern
    assign watch = (mode_q == XM_OFFLINE || mode_q == XM_BIAS) && wake_en_q &&
                   (!sel_en_q || !cfg_ok_q); // R10 R15

    always_ff @(posedge CLK_I) begin
        if (RST_I || !watch) begin
            wk_q <= WK_IDLE;
            ph_cnt_q <= '0;
            to_cnt_q <= '0;
        end else if (wk_q != WK_IDLE && to_cnt_q == TW'(WAKE_TO_CYCLES)) begin
            wk_q <= WK_IDLE; // R17
            ph_cnt_q <= '0;
            to_cnt_q <= '0;
        end else begin
            if (wk_q != WK_IDLE) to_cnt_q <= to_cnt_q + 1'b1;
            // short opposite bits restart only the phase count, not the pattern
            case (wk_q)
                WK_IDLE: begin
                    ph_cnt_q <= bus_q ? ph_cnt_q + 1'b1 : '0;
                    if (bus_q && ph_cnt_q == PW'(DOM_CYCLES - 1)) begin
                        wk_q <= WK_DOM1; // R16
                        ph_cnt_q <= '0;
                        to_cnt_q <= PW'(DOM_CYCLES) > 0 ? TW'(DOM_CYCLES) : '0;
                    end
                end
                WK_DOM1: begin
                    ph_cnt_q <= !bus_q ? ph_cnt_q + 1'b1 : '0;
                    if (!bus_q && ph_cnt_q == PW'(REC_CYCLES - 1)) begin
                        wk_q <= WK_REC; // R16
                        ph_cnt_q <= '0;
                    end
                end
                WK_REC: begin
                    ph_cnt_q <= bus_q ? ph_cnt_q + 1'b1 : '0;
                    if (bus_q && ph_cnt_q == PW'(DOM_CYCLES - 1)) begin
                        wk_q <= WK_DOM2; // R16
                    end
                end
                WK_DOM2: begin
                    wk_q <= WK_IDLE;
                    ph_cnt_q <= '0;
                    to_cnt_q <= '0;
                end
                default: wk_q <= WK_IDLE;
            endcase
        end
    end
    assign wake_hit = (wk_q == WK_DOM2) && watch;

    // transceiver mode
    logic off_prev_q;
    logic uv_bias;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            off_prev_q <= 1'b1;
        end else begin
            off_prev_q <= sup.offline_forced | sup.bat_uv;
        end
    end
    // low supply on field 01 holds bias, else silence would toggle bias and offline
    assign uv_bias = (dev_mode_q == DEV_NORMAL) && (field_q == FIELD_ACT_UV) && sup.vcc_uv;

    always_comb begin
        mode_d = mode_q;
        if (sup.offline_forced || sup.bat_uv) begin
            mode_d = XM_OFF; // R14
        end else if (off_prev_q || mode_q == XM_OFF) begin
            mode_d = XM_OFFLINE; // R12 R14
        end else if (dev_mode_q == DEV_NORMAL &&
                     (field_q == FIELD_ACT || (field_q == FIELD_ACT_UV && !sup.vcc_uv))) begin
            mode_d = txd_q ? XM_ACTIVE : XM_LISTEN; // R04 R07
            if (mode_q == XM_LISTEN && !txd_q) mode_d = XM_LISTEN; // R07
        end else if (dev_mode_q == DEV_NORMAL && field_q == FIELD_LISTEN) begin
            mode_d = XM_LISTEN; // R09
        end else if (dev_mode_q == DEV_NORMAL && field_q == FIELD_ACT_UV &&
                     (mode_q == XM_LISTEN || mode_q == XM_ACTIVE) && !txd_q) begin
            mode_d = XM_LISTEN; // R07
        end else if (mode_q == XM_ACTIVE || mode_q == XM_LISTEN) begin
            mode_d = (silent_q && !uv_bias) ? XM_OFFLINE : XM_BIAS; // R03 R05 R06 R11
        end else if (mode_q == XM_OFFLINE) begin
            if (edge_seen || wake_hit || uv_bias) begin
                mode_d = XM_BIAS; // R02 R13
            end
        end else if (mode_q == XM_BIAS) begin
            if (silent_q && !edge_seen && !uv_bias) mode_d = XM_OFFLINE; // R02 R13
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) mode_q <= XM_OFF;
        else mode_q <= mode_d;
    end

    // outputs
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RXD_O <= 1'b1;
            TX_ENABLE_O <= 1'b0;
            BIAS_MID_O <= 1'b0;
            BIAS_GND_O <= 1'b0;
            XCVR_ON_O <= 1'b0;
            REGULATOR_INHIBIT_OUT_O <= 1'b1;
        end else begin
            if (mode_q == XM_ACTIVE || mode_q == XM_LISTEN) RXD_O <= ~bus_q;
            else RXD_O <= ~wake_evt_q; // R18
            TX_ENABLE_O <= (mode_q == XM_ACTIVE) & txd_q;
            BIAS_MID_O <= mode_q inside {XM_ACTIVE, XM_LISTEN, XM_BIAS}; // R01
            BIAS_GND_O <= (mode_q == XM_OFFLINE); // R10
            XCVR_ON_O <= (mode_q != XM_OFF); // R14
            if (wake_hit) REGULATOR_INHIBIT_OUT_O <= 1'b1; // R19
            else if (dev_mode_q == DEV_SLEEP || sup.offline_forced)
                REGULATOR_INHIBIT_OUT_O <= 1'b0;
            else REGULATOR_INHIBIT_OUT_O <= 1'b1;
        end
    end
endmodule

// [can_mode_sva.sv]
// Purpose: port checks for transceiver mode control and bus wake
// Assumes: one clock, sync reset
// Notes: quiet and dominant age count on the raw bus input
module can_mode_sva
    import canmode_pkg::*;
#(
    parameter int SILENCE_CYCLES = SILENCE_CYC
) (
    // clock, reset, apb
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // conditions and bus
    input wire logic OFF_OR_OVERTEMP_I,
    input wire logic TXD_I,
    input wire logic BUS_DOMINANT_I,
    input wire logic RXD_O,
    input wire logic TX_ENABLE_O,
    input wire logic BIAS_MID_O,
    input wire logic BIAS_GND_O,
    input wire logic XCVR_ON_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic bus_q;
    int quiet_q;
    int dom_age_q;
    logic mapped;
    assign mapped = PADDR_I inside {ADDR_MODE, ADDR_CTRL, ADDR_STAT, ADDR_EVT};
    // reset loads SILENCE_CYCLES: the design's own timer start is not known
    always_ff @(posedge CLK_I) begin
        bus_q <= BUS_DOMINANT_I;
        if (RST_I) begin
            quiet_q <= SILENCE_CYCLES;
        end else if (BUS_DOMINANT_I != bus_q) begin
            quiet_q <= 0;
        end else if (quiet_q < 1000000) begin
            quiet_q <= quiet_q + 1;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            dom_age_q <= 255;
        end else if (BUS_DOMINANT_I) begin
            dom_age_q <= 0;
        end else if (dom_age_q < 255) begin
            dom_age_q <= dom_age_q + 1;
        end
    end
    ready_a: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
        else $error("pready low in access");
    decode_err_a: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == !mapped)
        else $error("slave error wrong for address");
    tx_bias_a: assert property (TX_ENABLE_O |-> BIAS_MID_O && !BIAS_GND_O)
        else $error("transmit without mid bias");
    gnd_bias_a: assert property (BIAS_GND_O |-> !BIAS_MID_O && !TX_ENABLE_O)
        else $error("ground bias overlaps mid bias");
    off_float_a: assert property (!XCVR_ON_O |-> !BIAS_MID_O && !BIAS_GND_O)
        else $error("bias while transceiver off");
    off_force_a: assert property (OFF_OR_OVERTEMP_I [*8] |-> !XCVR_ON_O)
        else $error("transceiver on in off mode");
    txd_low_a: assert property (!TXD_I [*8] |-> !TX_ENABLE_O)
        else $error("transmitter on with transmit input low");
    activity_a: assert property (BIAS_GND_O && $rose(BUS_DOMINANT_I) |-> ##[1:8] !BIAS_GND_O)
        else $error("no bias on bus activity");
    silence_a: assert property ($rose(BIAS_GND_O) && $past(XCVR_ON_O) |-> quiet_q >= SILENCE_CYCLES)
        else $error("offline before bus silence");
    wake_rxd_a: assert property ($fell(RXD_O) |-> dom_age_q < 8)
        else $error("receive output low without dominant bus");
    active_c: cover property (TX_ENABLE_O);
    offline_c: cover property ($rose(BIAS_GND_O));
    wake_c: cover property ($fell(RXD_O) && !TX_ENABLE_O);
endmodule

bind can_transceiver_mode_and_wake can_mode_sva #(.SILENCE_CYCLES(SILENCE_CYCLES)) chk_u (
    .CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PADDR_I, .PREADY_O, .PSLVERR_O,
    .OFF_OR_OVERTEMP_I, .TXD_I, .BUS_DOMINANT_I, .RXD_O, .TX_ENABLE_O,
    .BIAS_MID_O, .BIAS_GND_O, .XCVR_ON_O
);

// [can_far.sv]
// Purpose: protocol controller and bus model
// Assumes: bus idles recessive, held by termination
// Notes: phases are whole clock cycles
module can_far (
    input wire logic clk_i,
    output logic txd_o,
    output logic bus_dom_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        txd_o = 1'b1;
        bus_dom_o = 1'b0;
    end
    task set_txd(input logic t);
        txd_o <= t;
        @(posedge clk_i);
    endtask
    // dominant, recessive, dominant, then recessive idle
    task pattern(input int d1, input int r, input int d2);
        bus_dom_o <= 1'b1;
        repeat (d1) @(posedge clk_i);
        bus_dom_o <= 1'b0;
        repeat (r) @(posedge clk_i);
        bus_dom_o <= 1'b1;
        repeat (d2) @(posedge clk_i);
        bus_dom_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// [tb.sv]
// Purpose: bench for transceiver mode control and bus wake
// Assumes: shortened silence, wake and phase counts
// Notes: mode is read from the status code field
module tb
    import canmode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic e, off_ot, bat_uv, vcc_uv, uv_sleep, txd, bus_dom;
    logic rxd, tx_en, bias_mid, bias_gnd, xcvr_on, regulator_inhibit_out;
    int fails, n_tests, cyc;
    can_transceiver_mode_and_wake #(
        .SILENCE_CYCLES(50), .WAKE_TO_CYCLES(200), .DOM_CYCLES(5), .REC_CYCLES(5)
    ) uut (
        .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .OFF_OR_OVERTEMP_I(off_ot), .BAT_UV_I(bat_uv), .VCC_UV_I(vcc_uv),
        .UV_SLEEP_I(uv_sleep), .TXD_I(txd), .BUS_DOMINANT_I(bus_dom), .RXD_O(rxd),
        .TX_ENABLE_O(tx_en), .BIAS_MID_O(bias_mid), .BIAS_GND_O(bias_gnd),
        .XCVR_ON_O(xcvr_on), .REGULATOR_INHIBIT_OUT_O(regulator_inhibit_out)
    );
    can_far far (.clk_i(clk), .txd_o(txd), .bus_dom_o(bus_dom));
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // polls until the mode code shows up; the poll bound replaces a fixed wait
    task wait_mode(input logic [2:0] m);
        apb(1'b0, ADDR_STAT, 32'h0);
        for (int i = 0; i < 40 && r[2:0] !== m; i++) apb(1'b0, ADDR_STAT, 32'h0);
        chk("mode code", 32'(r[2:0]), 32'(m));
    endtask
    task t_regs;
        apb(1'b0, ADDR_MODE, 32'h0);
        chk("mode reg", r, 32'h4);
        // a write with no byte lane enabled must leave the register alone
        pstrb <= 4'h0;
        apb(1'b1, ADDR_CTRL, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reg", r, 32'h40);
        apb(1'b1, 12'h0FC, 32'hFF);
        chk("write err", 32'(e), 32'h1);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("read err", {e, r[30:0]}, 32'h80000000);
        wait_mode(3'h1);
        chk("gnd bias", 32'(bias_gnd), 32'h1);
    endtask
    task t_normal;
        logic [2:0] m [4] = '{3'h4, 3'h4, 3'h3, 3'h1};
        apb(1'b1, ADDR_MODE, 32'h7);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CTRL, {24'h0, 6'h10, 2'(i + 1)});
            wait_mode(m[i]);
            chk("tx enable", 32'(tx_en), 32'(m[i] == 3'h4));
            chk("mid bias", 32'(bias_mid), 32'(m[i] != 3'h1));
            apb(1'b0, ADDR_STAT, 32'h0);
            chk("status bit", 32'(r[7]), 32'(m[i] == 3'h4));
        end
    endtask
    task t_uv;
        apb(1'b1, ADDR_CTRL, 32'h41);
        wait_mode(3'h4);
        vcc_uv <= 1'b1;
        wait_mode(3'h2);
        apb(1'b1, ADDR_CTRL, 32'h42);
        wait_mode(3'h4);
        uv_sleep <= 1'b1;
        wait_mode(3'h1);
        chk("inh sleep", 32'(regulator_inhibit_out), 32'h0);
        uv_sleep <= 1'b0;
        vcc_uv <= 1'b0;
        // let the synchronised sleep force drop first, or normal is forced back to sleep
        repeat (8) @(posedge clk);
        apb(1'b1, ADDR_MODE, 32'h7);
    endtask
    task t_txd;
        far.set_txd(1'b0);
        apb(1'b1, ADDR_CTRL, 32'h41);
        wait_mode(3'h3);
        chk("tx held", 32'(tx_en), 32'h0);
        far.set_txd(1'b1);
        wait_mode(3'h4);
    endtask
    task t_wake;
        logic [7:0] ctl [4] = '{8'h00, 8'h50, 8'h40, 8'h40};
        logic [2:0] dev [4] = '{3'h4, 3'h4, 3'h4, 3'h1};
        int gap [4] = '{8, 8, 250, 8};
        logic ev [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CTRL, {24'h0, ctl[i]});
            apb(1'b1, ADDR_MODE, {29'h0, dev[i]});
            wait_mode(3'h1);
            chk("rxd idle", 32'(rxd), 32'h1);
            chk("inh before", 32'(regulator_inhibit_out), 32'(dev[i] != 3'h1));
            far.pattern(8, gap[i], 8);
            repeat (8) @(posedge clk);
            apb(1'b0, ADDR_EVT, 32'h0);
            chk("wake event", r, 32'(ev[i]));
            chk("rxd wake", 32'(rxd), 32'(!ev[i]));
            chk("inh after", 32'(regulator_inhibit_out), 32'h1);
            apb(1'b0, ADDR_MODE, 32'h0);
            chk("device mode", r, 32'h4);
            apb(1'b1, ADDR_EVT, 32'h1);
            // disabling the watch clears a half-seen pattern before the next pass
            apb(1'b1, ADDR_CTRL, 32'h0);
        end
    endtask
    task t_off;
        off_ot <= 1'b1;
        wait_mode(3'h0);
        chk("floating", {29'h0, xcvr_on, bias_mid, bias_gnd}, 32'h0);
        off_ot <= 1'b0;
        wait_mode(3'h1);
        bat_uv <= 1'b1;
        wait_mode(3'h0);
        bat_uv <= 1'b0;
        wait_mode(3'h1);
    endtask
    task give_verdict;
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // a hung handshake or poll ends here instead of running on
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {off_ot, bat_uv, vcc_uv, uv_sleep} = 4'h0;
        pstrb = 4'hF;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_normal();
        t_uv();
        t_txd();
        t_wake();
        t_off();
        give_verdict();
    end
endmodule
